// ==== urd_pkg.sv ====
// Package for the UART register access decode block.
// Assumes one 100 MHz clock and an 8-bit host port with 3 address lines.
package urd_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] OFS_DIVISOR_LOW      = 3'h0;
    localparam logic [2:0] OFS_DIVISOR_HIGH     = 3'h1;
    localparam logic [2:0] OFS_ENHANCED_FEATURE = 3'h2;
    localparam logic [2:0] OFS_LINE_CONTROL     = 3'h3;
    localparam logic [2:0] OFS_MODEM_CONTROL    = 3'h4;
    localparam logic [2:0] OFS_RESUME_CHAR_ONE  = 3'h4;
    localparam logic [2:0] OFS_RESUME_CHAR_TWO  = 3'h5;
    localparam logic [2:0] OFS_PAUSE_CHAR_ONE   = 3'h6;
    localparam logic [2:0] OFS_PAUSE_CHAR_TWO   = 3'h7;
    localparam logic [2:0] OFS_FLOW_THRESHOLD   = 3'h6;
    localparam logic [2:0] OFS_FIFO_TRIGGER     = 3'h7;
    localparam logic [2:0] OFS_FIFO_READY       = 3'h7;

    // ----------------------------------------------------------------
    // Access keys and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] LINE_CONTROL_DIV_KEY = 8'h80;
    localparam logic [7:0] LINE_CONTROL_ENH_KEY = 8'hbf;
    localparam int         LINE_CONTROL_DIV_BIT = 7;
    localparam int         ENH_FEATURE_EXT_BIT  = 4;
    localparam int         MODEM_CONTROL_EXT_BIT = 6;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [2:0] SYNC_ADDR_RESET = 3'h0;
    localparam logic [7:0] SYNC_DATA_RESET = 8'h00;
    localparam logic [2:0] SYNC_STROBE_RESET = 3'h7;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SEL_BASE, SEL_LINE_CONTROL, SEL_MODEM_CONTROL, SEL_DIV_LOW, SEL_DIV_HIGH,
        SEL_ENH_FEATURE, SEL_RESUME_ONE, SEL_RESUME_TWO, SEL_PAUSE_ONE,
        SEL_PAUSE_TWO, SEL_FLOW_THRESHOLD, SEL_FIFO_TRIGGER, SEL_FIFO_READY
    } urd_sel_t;

    typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} urd_bus_t;

    typedef struct packed {
        logic [7:0] divisor_low;
        logic [7:0] divisor_high;
        logic [7:0] enhanced_feature;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] resume_char_one;
        logic [7:0] resume_char_two;
        logic [7:0] pause_char_one;
        logic [7:0] pause_char_two;
        logic [7:0] flow_threshold;
        logic [7:0] fifo_trigger_level;
    } urd_cfg_t;

endpackage

// ==== urd_sync.sv ====
// Two-stage synchroniser for a group of host pins.
// Assumes the pins are asynchronous to sys_clk; reset value is a constant.
`timescale 1ns/1ps
module urd_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Pins and synchronised copy
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] pin_sync
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q   <= RST_VAL;
            pin_sync <= RST_VAL;
        end else begin
            meta_q   <= pin;
            pin_sync <= meta_q;
        end
    end

endmodule

// ==== urd_decode.sv ====
// Address decode: which register an offset reaches under the current
// access settings. Purely combinational, same clock as its user.
`timescale 1ns/1ps
module urd_decode (
    // Access settings
    input  wire logic [7:0]     line_control,
    input  wire logic [7:0]     enhanced_feature,
    input  wire logic [7:0]     modem_control,
    // Offset and result
    input  wire logic [2:0]     addr,
    output urd_pkg::urd_sel_t   sel
);

    logic div_mode;
    logic key_mode;
    logic ext_mode;
    logic ready_mode;

    assign div_mode   = line_control[urd_pkg::LINE_CONTROL_DIV_BIT];
    assign key_mode   = (line_control == urd_pkg::LINE_CONTROL_ENH_KEY);
    // Threshold view needs enhanced_feature bit 4 and modem_control bit 6 set with line_control bit 7 clear
    assign ext_mode   = enhanced_feature[urd_pkg::ENH_FEATURE_EXT_BIT] && !div_mode
                        && modem_control[urd_pkg::MODEM_CONTROL_EXT_BIT];
    assign ready_mode = !enhanced_feature[urd_pkg::ENH_FEATURE_EXT_BIT] && !div_mode
                        && modem_control[urd_pkg::MODEM_CONTROL_EXT_BIT];

    assign sel =
        (addr == urd_pkg::OFS_LINE_CONTROL)                 ? urd_pkg::SEL_LINE_CONTROL :
        (div_mode && addr == urd_pkg::OFS_DIVISOR_LOW)      ? urd_pkg::SEL_DIV_LOW :
        (div_mode && addr == urd_pkg::OFS_DIVISOR_HIGH)     ? urd_pkg::SEL_DIV_HIGH :
        (key_mode && addr == urd_pkg::OFS_ENHANCED_FEATURE) ? urd_pkg::SEL_ENH_FEATURE :
        (key_mode && addr == urd_pkg::OFS_RESUME_CHAR_ONE)  ? urd_pkg::SEL_RESUME_ONE :
        (key_mode && addr == urd_pkg::OFS_RESUME_CHAR_TWO)  ? urd_pkg::SEL_RESUME_TWO :
        (key_mode && addr == urd_pkg::OFS_PAUSE_CHAR_ONE)   ? urd_pkg::SEL_PAUSE_ONE :
        (key_mode && addr == urd_pkg::OFS_PAUSE_CHAR_TWO)   ? urd_pkg::SEL_PAUSE_TWO :
        (addr == urd_pkg::OFS_MODEM_CONTROL)                ? urd_pkg::SEL_MODEM_CONTROL :
        (ext_mode && addr == urd_pkg::OFS_FLOW_THRESHOLD)   ? urd_pkg::SEL_FLOW_THRESHOLD :
        (ext_mode && addr == urd_pkg::OFS_FIFO_TRIGGER)     ? urd_pkg::SEL_FIFO_TRIGGER :
        (ready_mode && addr == urd_pkg::OFS_FIFO_READY)     ? urd_pkg::SEL_FIFO_READY :
                                                              urd_pkg::SEL_BASE;

endmodule

// ==== urd_regs.sv ====
// Register bank and access decode of one UART channel on the host port.
// Assumes an 8-bit asynchronous host bus (chip select, read, write strobes)
// and fifo ready flags from logic on sys_clk.
`timescale 1ns/1ps
module urd_regs (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Host bus pins
    input  wire logic                 host_cs_n,
    input  wire logic                 host_rd_n,
    input  wire logic                 host_wr_n,
    input  wire logic [2:0]           host_addr,
    input  wire logic [7:0]           host_data_pin,
    output logic      [7:0]           host_data_drv,
    output logic                      host_data_oe_n,
    // Channel side
    input  wire logic [7:0]           fifo_ready_view,
    output urd_pkg::urd_cfg_t         cfg
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] strobe_s;
    logic [2:0] addr_s;
    logic [7:0] data_s;
    logic       cs_n_s;
    logic       rd_n_s;
    logic       wr_n_s;

    urd_sync #(.W(3), .RST_VAL(urd_pkg::SYNC_STROBE_RESET)) u_sync_strobe (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin      ({host_cs_n, host_rd_n, host_wr_n}),
        .pin_sync (strobe_s)
    );

    urd_sync #(.W(3), .RST_VAL(urd_pkg::SYNC_ADDR_RESET)) u_sync_addr (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin      (host_addr),
        .pin_sync (addr_s)
    );

    urd_sync #(.W(8), .RST_VAL(urd_pkg::SYNC_DATA_RESET)) u_sync_data (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin      (host_data_pin),
        .pin_sync (data_s)
    );

    assign cs_n_s = strobe_s[2];
    assign rd_n_s = strobe_s[1];
    assign wr_n_s = strobe_s[0];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] line_control_q;
    logic [7:0] modem_control_q;
    logic [7:0] enhanced_feature_q;
    logic [7:0] divisor_low_q;
    logic [7:0] divisor_high_q;
    logic [7:0] resume_char_one_q;
    logic [7:0] resume_char_two_q;
    logic [7:0] pause_char_one_q;
    logic [7:0] pause_char_two_q;
    logic [7:0] flow_threshold_q;
    logic [7:0] fifo_trigger_level_q;
    // Plain base holding registers for the offsets this bank does not own
    logic [7:0] base_q [8];

    // ----------------------------------------------------------------
    // Bus sequencer
    // ----------------------------------------------------------------
    urd_pkg::urd_bus_t state_q;
    urd_pkg::urd_bus_t state_d;
    logic [2:0]        wr_addr_q;
    logic [7:0]        wr_data_q;
    logic              wr_req;
    logic              rd_req;
    logic              rd_active;
    logic              commit;

    assign wr_req    = !cs_n_s && !wr_n_s;
    assign rd_req    = !cs_n_s && !rd_n_s;
    assign rd_active = rd_req && (state_q != urd_pkg::BUS_WRITE);
    // Commit on the trailing edge so data is stable when stored
    assign commit    = (state_q == urd_pkg::BUS_WRITE) && !wr_req;

    always_comb begin
        state_d = state_q;
        case (state_q)
            urd_pkg::BUS_IDLE: begin
                if (wr_req) begin
                    state_d = urd_pkg::BUS_WRITE;
                end else if (rd_req) begin
                    state_d = urd_pkg::BUS_READ;
                end
            end
            urd_pkg::BUS_READ: begin
                if (!rd_req) begin
                    state_d = urd_pkg::BUS_IDLE;
                end
            end
            urd_pkg::BUS_WRITE: begin
                if (!wr_req) begin
                    state_d = urd_pkg::BUS_IDLE;
                end
            end
            default: begin
                state_d = urd_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= urd_pkg::BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Last sample taken while the strobe was still low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_addr_q <= urd_pkg::SYNC_ADDR_RESET;
            wr_data_q <= urd_pkg::SYNC_DATA_RESET;
        end else if (wr_req && state_q != urd_pkg::BUS_READ) begin
            wr_addr_q <= addr_s;
            wr_data_q <= data_s;
        end
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    urd_pkg::urd_sel_t wr_sel;
    urd_pkg::urd_sel_t rd_sel;

    urd_decode u_dec_wr (
        .line_control     (line_control_q),
        .enhanced_feature (enhanced_feature_q),
        .modem_control    (modem_control_q),
        .addr             (wr_addr_q),
        .sel              (wr_sel)
    );

    urd_decode u_dec_rd (
        .line_control     (line_control_q),
        .enhanced_feature (enhanced_feature_q),
        .modem_control    (modem_control_q),
        .addr             (addr_s),
        .sel              (rd_sel)
    );

    function automatic logic hit(input urd_pkg::urd_sel_t s, input urd_pkg::urd_sel_t t);
        hit = (s == t);
    endfunction

    logic we_line;
    logic we_modem;
    logic we_enh;
    logic we_div_lo;
    logic we_div_hi;
    logic we_res1;
    logic we_res2;
    logic we_pau1;
    logic we_pau2;
    logic we_flow;
    logic we_trig;
    logic we_base;

    assign we_line   = commit && hit(wr_sel, urd_pkg::SEL_LINE_CONTROL);
    assign we_modem  = commit && hit(wr_sel, urd_pkg::SEL_MODEM_CONTROL);
    assign we_enh    = commit && hit(wr_sel, urd_pkg::SEL_ENH_FEATURE);
    assign we_div_lo = commit && hit(wr_sel, urd_pkg::SEL_DIV_LOW);
    assign we_div_hi = commit && hit(wr_sel, urd_pkg::SEL_DIV_HIGH);
    assign we_res1   = commit && hit(wr_sel, urd_pkg::SEL_RESUME_ONE);
    assign we_res2   = commit && hit(wr_sel, urd_pkg::SEL_RESUME_TWO);
    assign we_pau1   = commit && hit(wr_sel, urd_pkg::SEL_PAUSE_ONE);
    assign we_pau2   = commit && hit(wr_sel, urd_pkg::SEL_PAUSE_TWO);
    assign we_flow   = commit && hit(wr_sel, urd_pkg::SEL_FLOW_THRESHOLD);
    assign we_trig   = commit && hit(wr_sel, urd_pkg::SEL_FIFO_TRIGGER);
    // Fifo ready view is read-only, so its writes fall nowhere
    assign we_base   = commit && hit(wr_sel, urd_pkg::SEL_BASE);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // control writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            line_control_q     <= urd_pkg::REG_RESET_VAL;
            modem_control_q    <= urd_pkg::REG_RESET_VAL;
            enhanced_feature_q <= urd_pkg::REG_RESET_VAL;
        end else begin
            if (we_line) line_control_q <= wr_data_q;
            if (we_modem) modem_control_q <= wr_data_q;
            if (we_enh) enhanced_feature_q <= wr_data_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            divisor_low_q        <= urd_pkg::REG_RESET_VAL;
            divisor_high_q       <= urd_pkg::REG_RESET_VAL;
            resume_char_one_q    <= urd_pkg::REG_RESET_VAL;
            resume_char_two_q    <= urd_pkg::REG_RESET_VAL;
            pause_char_one_q     <= urd_pkg::REG_RESET_VAL;
            pause_char_two_q     <= urd_pkg::REG_RESET_VAL;
            flow_threshold_q     <= urd_pkg::REG_RESET_VAL;
            fifo_trigger_level_q <= urd_pkg::REG_RESET_VAL;
        end else begin
            if (we_div_lo) divisor_low_q <= wr_data_q;
            if (we_div_hi) divisor_high_q <= wr_data_q;
            if (we_res1) resume_char_one_q <= wr_data_q;
            if (we_res2) resume_char_two_q <= wr_data_q;
            if (we_pau1) pause_char_one_q <= wr_data_q;
            if (we_pau2) pause_char_two_q <= wr_data_q;
            if (we_flow) flow_threshold_q <= wr_data_q;
            if (we_trig) fifo_trigger_level_q <= wr_data_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                base_q[i] <= urd_pkg::REG_RESET_VAL;
            end
        end else if (we_base) begin
            base_q[wr_addr_q] <= wr_data_q;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rd_data;

    assign rd_data =
        (rd_sel == urd_pkg::SEL_LINE_CONTROL)   ? line_control_q :
        (rd_sel == urd_pkg::SEL_MODEM_CONTROL)  ? modem_control_q :
        (rd_sel == urd_pkg::SEL_ENH_FEATURE)    ? enhanced_feature_q :
        (rd_sel == urd_pkg::SEL_DIV_LOW)        ? divisor_low_q :
        (rd_sel == urd_pkg::SEL_DIV_HIGH)       ? divisor_high_q :
        (rd_sel == urd_pkg::SEL_RESUME_ONE)     ? resume_char_one_q :
        (rd_sel == urd_pkg::SEL_RESUME_TWO)     ? resume_char_two_q :
        (rd_sel == urd_pkg::SEL_PAUSE_ONE)      ? pause_char_one_q :
        (rd_sel == urd_pkg::SEL_PAUSE_TWO)      ? pause_char_two_q :
        (rd_sel == urd_pkg::SEL_FLOW_THRESHOLD) ? flow_threshold_q :
        (rd_sel == urd_pkg::SEL_FIFO_TRIGGER)   ? fifo_trigger_level_q :
        (rd_sel == urd_pkg::SEL_FIFO_READY)     ? fifo_ready_view :
                                                  base_q[addr_s];

    // Data follows the offset for as long as the read strobe is low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            host_data_drv  <= urd_pkg::REG_RESET_VAL;
            host_data_oe_n <= 1'b1;
        end else begin
            host_data_oe_n <= !rd_active;
            if (rd_active) host_data_drv <= rd_data;
        end
    end

    // Host restores its saved values afterwards; nothing here undoes them
    assign cfg = '{divisor_low:        divisor_low_q,
                   divisor_high:       divisor_high_q,
                   enhanced_feature:   enhanced_feature_q,
                   line_control:       line_control_q,
                   modem_control:      modem_control_q,
                   resume_char_one:    resume_char_one_q,
                   resume_char_two:    resume_char_two_q,
                   pause_char_one:     pause_char_one_q,
                   pause_char_two:     pause_char_two_q,
                   flow_threshold:     flow_threshold_q,
                   fifo_trigger_level: fifo_trigger_level_q};

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_base_by_addr: assert property (
        !line_control_q[7] && !modem_control_q[6] && addr_s != urd_pkg::OFS_LINE_CONTROL
        && addr_s != urd_pkg::OFS_MODEM_CONTROL |-> rd_sel == urd_pkg::SEL_BASE)
        else $error("base offset reached a keyed register");

    a_line_ctl_rw: assert property (
        we_line |=> line_control_q == $past(wr_data_q))
        else $error("line control not stored");

    a_line_ctl_read: assert property (
        rd_active && addr_s == urd_pkg::OFS_LINE_CONTROL |=> !host_data_oe_n
        && host_data_drv == $past(line_control_q))
        else $error("line control not read back");

    a_div_gate: assert property (
        (we_div_lo || we_div_hi) |-> line_control_q[7] && wr_addr_q[2:1] == 2'b00)
        else $error("divisor written outside divisor view");

    a_enh_gate: assert property (
        we_enh |-> line_control_q == 8'hbf ##1 enhanced_feature_q == $past(wr_data_q))
        else $error("enhanced feature write not keyed or lost");

    a_char_one: assert property (
        we_pau1 || we_res1 |-> line_control_q == 8'hbf && wr_addr_q[2] && !wr_addr_q[0])
        else $error("first flow character written outside keyed view");

    a_char_two: assert property (
        we_pau2 |=> pause_char_two_q == $past(wr_data_q) && $stable(pause_char_one_q))
        else $error("second pause character not stored");

    a_thresh_gate: assert property (
        we_flow |-> enhanced_feature_q[4] && !line_control_q[7] && modem_control_q[6]
        && wr_addr_q == 3'h6)
        else $error("threshold written without access bits");

    a_trig_gate: assert property (
        we_trig |=> fifo_trigger_level_q == $past(wr_data_q) && $past(modem_control_q[6]))
        else $error("trigger level write wrong");

    a_ready_read: assert property (
        rd_active && rd_sel == urd_pkg::SEL_FIFO_READY |=> host_data_drv
        == $past(fifo_ready_view) && !host_data_oe_n)
        else $error("fifo ready view not returned");

    a_ext_hold: assert property (
        !commit |=> $stable(flow_threshold_q) && $stable(fifo_trigger_level_q)
        && $stable(divisor_low_q) && $stable(pause_char_two_q))
        else $error("extended value changed without a write");

    c_div_write: cover property (we_div_lo ##[1:50] we_div_hi);
    c_thresh_write: cover property (we_flow);
    c_ready_read: cover property (rd_active && rd_sel == urd_pkg::SEL_FIFO_READY);
    c_restore: cover property (we_trig ##[1:200] we_line);

endmodule

// ==== urd_host_model.sv ====
// Host model: one processor driving the channel's parallel port.
// Assumes one access at a time, issued from the bench.
`timescale 1ns/1ps
module urd_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Host bus
    output logic            host_cs_n,
    output logic            host_rd_n,
    output logic            host_wr_n,
    output logic [2:0]      host_addr,
    output logic [7:0]      host_dq,
    input  wire logic [7:0] host_data_drv,
    input  wire logic       host_data_oe_n
);
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    initial begin
        host_cs_n = 1'b1;
        host_rd_n = 1'b1;
        host_wr_n = 1'b1;
        host_addr = 3'h0;
        host_dq   = 8'h5a;
    end

    // Address settles before strobes; data inverted once hold is over
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host_addr <= a;
        host_dq   <= d;
        repeat (2) @(posedge sys_clk);
        host_cs_n <= 1'b0;
        host_wr_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        host_cs_n <= 1'b1;
        host_wr_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        host_dq   <= ~d;
        repeat (3) @(posedge sys_clk);
    endtask

    // Undriven bus reads as unknown so a missing answer cannot match
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        host_addr <= a;
        repeat (2) @(posedge sys_clk);
        host_cs_n <= 1'b0;
        host_rd_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        d = host_data_oe_n ? 8'hxx : host_data_drv;
        host_cs_n <= 1'b1;
        host_rd_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask
endmodule

// ==== tb_top.sv ====
// Testbench for the channel register decode.
// Assumes the host model keeps the strobe spacing of the port.
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------------------------------
    // Wiring, checks and sequence
    // ----------------------------------------------------------------
    logic              sys_clk;
    logic              rst;
    logic              host_cs_n;
    logic              host_rd_n;
    logic              host_wr_n;
    logic [2:0]        host_addr;
    logic [7:0]        host_dq;
    logic [7:0]        host_data_drv;
    logic              host_data_oe_n;
    logic [7:0]        fifo_view;
    logic [7:0]        k [5];
    logic [7:0]        t;
    logic [7:0]        l;
    int                seed = 70;
    int                n_fail = 0;
    int                compares = 0;
    int                cyc = 0;
    urd_pkg::urd_cfg_t cfg;
    wire logic [7:0]   host_data_pin = host_data_oe_n ? host_dq : host_data_drv;
    localparam logic [2:0] KOFS [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    urd_regs urd_regs_i (.sys_clk(sys_clk), .rst(rst), .host_cs_n(host_cs_n),
        .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
        .host_data_pin(host_data_pin), .host_data_drv(host_data_drv),
        .host_data_oe_n(host_data_oe_n), .fifo_ready_view(fifo_view), .cfg(cfg));
    urd_host_model urd_host_model_i (.sys_clk(sys_clk), .host_cs_n(host_cs_n),
        .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
        .host_dq(host_dq), .host_data_drv(host_data_drv),
        .host_data_oe_n(host_data_oe_n));

    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic w(input logic [2:0] a, input logic [7:0] d);
        urd_host_model_i.wr(a, d);
    endtask

    task automatic rc(input string n, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] r;
        urd_host_model_i.rd(a, r);
        chk(n, e, r);
    endtask

    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run is under 2000 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        rst = 1'b1;
        fifo_view = 8'h00;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rc("line_control reset", 3'h3, 8'h00);
        t = rnd() & 8'h7f;
        w(3'h3, t);
        rc("line_control", 3'h3, t);
        t = rnd();
        l = rnd();
        w(3'h3, 8'h80);
        w(3'h0, t);
        w(3'h1, l);
        w(3'h3, 8'h00);
        chk("divisor_low", t, cfg.divisor_low);
        chk("divisor_high", l, cfg.divisor_high);
        rc("base byte 00", 3'h0, 8'h00);
        w(3'h3, 8'h80);
        rc("divisor_high kept", 3'h1, l);
        w(3'h3, 8'hbf);
        foreach (k[i]) begin
            k[i] = (i == 0) ? (rnd() & 8'hef) : rnd();
            w(KOFS[i], k[i]);
        end
        foreach (k[i])
            rc("keyed register", KOFS[i], k[i]);
        w(3'h3, 8'h00);
        rc("modem_control", 3'h4, 8'h00);
        w(3'h3, 8'hbf);
        w(3'h2, k[0] | 8'h10);
        w(3'h3, 8'h00);
        w(3'h4, 8'h40);
        t = rnd();
        l = rnd();
        w(3'h6, t);
        w(3'h7, l);
        rc("flow_threshold", 3'h6, t);
        chk("fifo_trigger_level", l, cfg.fifo_trigger_level);
        chk("pause_char_one kept", k[3], cfg.pause_char_one);
        w(3'h3, 8'hbf);
        w(3'h2, k[0]);
        w(3'h3, 8'h00);
        chk("enhanced_feature", k[0], cfg.enhanced_feature);
        t = rnd();
        fifo_view <= t;
        rc("fifo_ready_status", 3'h7, t);
        w(3'h7, ~l);
        chk("trigger after dropped write", l, cfg.fifo_trigger_level);
        w(3'h4, 8'h00);
        rc("base byte 07", 3'h7, 8'h00);
        chk("pause_char_two kept", k[4], cfg.pause_char_two);
        // Mid-run reset clears the extended values
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        chk("pause_char_two after reset", 8'h00, cfg.pause_char_two);
        chk("divisor_high after reset", 8'h00, cfg.divisor_high);
        rc("line_control after reset", 3'h3, 8'h00);
        results();
    end
endmodule
